/* design/sense_params.svh */
`ifndef SENSE_PARAMS_SVH
`define SENSE_PARAMS_SVH

// apb geometry
`define ADDR_W            8
`define DATA_W            32
`define IDX_W             6
`define IDX_LSB           2

// register indexes, byte address is four times the index
`define IDX_DRIVE_COND    6'h04
`define IDX_SUBSYS_MODE   6'h05
`define IDX_SPARE_SIX     6'h06
`define IDX_ERASE_STAT    6'h07
`define IDX_VEL_RESERVE   6'h09
`define IDX_TM_CHECK      6'h0A
`define IDX_FEAT_ID_HI    6'h0D
`define IDX_ID_LOW        6'h0E
`define IDX_SW_FEATURES   6'h11
`define IDX_PRIMED_LOW    6'h13
`define IDX_PRIMED_HIGH   6'h14
`define IDX_CONFIG        6'h20
`define IDX_STATUS        6'h21
`define IDX_CLEAR         6'h22

// sticky sense flag slots
`define NFLAGS            6
`define F_TAPE_IND        0
`define F_WPARITY         1
`define F_START_READ      2
`define F_VELOCITY        3
`define F_WTM_MISS        4
`define F_DRV_REJECT      5

// sense bit positions inside their bytes
`define B4_REJECT         1
`define B4_TAPE_IND       2
`define B4_WPARITY        3
`define B4_START_READ     4
`define B4_LWR            5
`define B5_NEW_SUBSYS     1
`define B5_START_READ     4
`define B9_VELOCITY       1
`define B9_RESERVE        7
`define B10_WTM_MISS      4
`define B17_TWO_CS        0

// clear register bits
`define CLR_SENSE         0
`define CLR_UNIT_CHECK    1

// config reset value: extended mode, no options
`define CONFIG_RESET      32'h0000_0001

`endif

/* design/sense_pkg.sv */
package sense_pkg;

   // drive-side condition inputs
   typedef struct packed {
      logic        eot_marker;
      logic        forward;
      logic        write_parity_bad;
      logic        read_op;
      logic        inter_block_gap;
      logic        beginning_burst;
      logic        ones_marker;
      logic        loop_write_read;
      logic        velocity_error;
      logic        reserved;
      logic        write_tape_mark_op;
      logic        block_missing;
      logic        drive_ready;
      logic        read_status_change;
      logic        motion_cmd;
      logic        backward_op;
      logic        rewind_op;
      logic        load_point;
      logic        rewind_unload;
      logic        not_capable;
      logic [15:0] primed;
   } drive_events_s;

   // channel-side request inputs
   typedef struct packed {
      logic       test_io;
      logic       start_io;
      logic       cmd_is_sense;
      logic       status_taken;
      logic       select_in;
      logic       address_out;
      logic [7:0] bus_out;
   } channel_req_s;

   // software configuration word
   typedef struct packed {
      logic [2:0]  spare;
      logic [3:0]  unit_base;
      logic [1:0]  features;
      logic [13:0] serial_id;
      logic [3:0]  revision_level;
      logic [2:0]  switch_code;
      logic        two_channel_switch;
      logic        extended_mode;
   } config_s;

   typedef enum logic [1:0] {
      APB_IDLE,
      APB_WAIT,
      APB_DONE
   } apb_state_e;

   typedef logic [7:0] sense_byte_t;

endpackage : sense_pkg

/* design/sense_flag.sv */
`timescale 1ns/1ns
// sticky flag, a set in the same cycle as a clear wins
module sense_flag (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= 1'b0;
      else if (set)
         q <= 1'b1;
      else if (clr)
         q <= 1'b0;
   end

endmodule : sense_flag

/* design/select_block.sv */
`timescale 1ns/1ns
`include "sense_params.svh"
// stops select propagation once our own address is seen on bus-out
module select_block (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       select_in,
   input  wire logic       address_out,
   input  wire logic [7:0] bus_out,
   input  wire logic [3:0] unit_base,
   output logic            blocked_q,
   output logic            select_out_q
);

   logic hit;
   logic blocked_d;

   // own address when the high nibble names this controller
   assign hit       = address_out && (bus_out[7:4] == unit_base);
   assign blocked_d = select_in && (blocked_q || hit);

   // block holds until select drops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         blocked_q    <= 1'b0;
         select_out_q <= 1'b0;
      end
      else
      begin
         blocked_q    <= blocked_d;
         select_out_q <= select_in && !blocked_d;
      end
   end

endmodule : select_block

/* design/tape_control_sense_status.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ns
`include "sense_params.svh"
// Summary of operation
// - extended mode: end-of-tape marker while moving forward sets byte 4 bit 2
// - bad parity from the write triggers sets byte 4 bit 3
// - legacy mode: start read check shown in byte 4 bit 4
// - extended mode: byte 4 bit 5 high during loop write-to-read
// - byte 5 bit 0 zero; bit 1 one in extended, zero in legacy
// - extended read: gap after beginning burst, before ones marker, sets 5.4
// - bytes 6 to 23 supplied only in extended mode
// - capstan velocity out of limits sets byte 9 bit 1
// - byte 9 bit 7 while reserved, only with two-channel switch option
// - write tape mark with block not detected sets byte 10 bit 4
// - serial id high part in byte 13 upper bits, low part in 14
// - byte 17 bit 0 shows two-channel switch option present
// - byte 17 bits 4 to 7 carry the revision level
// - byte 17 bits 1 to 3 carry the switch configuration code
// - byte 19 bit 0 is drive 7 down to bit 7 drive 0
// - next byte bit 0 is drive F down to bit 7 drive 8
// - test I/O to a not ready drive raises unit check
// - start I/O, not sense, to a not ready drive raises unit check
// - backward motion other than rewind into load point raises unit check
// - rewind-unload start raises unit check, device end and cu end
// - not-capable sense bit raises unit check
// - select stops propagating once own address decoded on bus-out
// - drive drops ready in motion or read status changes: byte 4 bit 1
module tape_control_sense_status (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`ADDR_W-1:0]      paddr,
   input  wire logic [`DATA_W-1:0]      pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic [`DATA_W-1:0]           prdata,
   output logic                         pslverr,
   input  wire sense_pkg::drive_events_s drv,
   input  wire sense_pkg::channel_req_s  chan,
   output logic                         unit_check,
   output logic                         device_end,
   output logic                         cu_end,
   output logic                         select_out,
   output logic                         select_blocked
);

   sense_pkg::config_s     cfg_q;
   sense_pkg::apb_state_e  apb_q;
   sense_pkg::apb_state_e  apb_d;
   logic [`NFLAGS-1:0]     flag_set;
   logic [`NFLAGS-1:0]     flag_q;
   logic                   clr_sense;
   logic                   clr_uc;
   logic                   uc_event;
   logic                   lwr_q;
   logic                   reserve_q;
   logic [15:0]            primed_q;
   logic                   uc_q;
   logic                   de_q;
   logic                   cue_q;
   logic                   access;
   logic                   wr_take;
   logic                   rd_take;
   logic [`IDX_W-1:0]      idx;
   logic [`DATA_W-1:0]     rd_word;
   logic                   ext;
   sense_pkg::sense_byte_t primed_low;
   sense_pkg::sense_byte_t primed_high;

   // aligned word at a known index
   function automatic logic mapped(input logic [`ADDR_W-1:0] a);
      logic [`IDX_W-1:0] i;
      i = a[`ADDR_W-1:`IDX_LSB];
      mapped = (a[`IDX_LSB-1:0] == 2'h0) &&
               ((i == `IDX_DRIVE_COND) || (i == `IDX_SUBSYS_MODE) ||
                (i == `IDX_SPARE_SIX) || (i == `IDX_ERASE_STAT) ||
                (i == `IDX_VEL_RESERVE) || (i == `IDX_TM_CHECK) ||
                (i == `IDX_FEAT_ID_HI) || (i == `IDX_ID_LOW) ||
                (i == `IDX_SW_FEATURES) || (i == `IDX_PRIMED_LOW) ||
                (i == `IDX_PRIMED_HIGH) || (i == `IDX_CONFIG) ||
                (i == `IDX_STATUS) || (i == `IDX_CLEAR));
   endfunction : mapped

   // word index of a bus address
   function automatic logic [`IDX_W-1:0] word_index(
      input logic [`ADDR_W-1:0] a);
      word_index = a[`ADDR_W-1:`IDX_LSB];
   endfunction : word_index

   assign ext = cfg_q.extended_mode;
   assign idx = word_index(paddr);

   // apb transfer: one wait state; a write lands as pready is seen high
   assign access  = psel && penable && (apb_q == sense_pkg::APB_WAIT);
   assign wr_take = psel && penable && pready && pwrite && mapped(paddr);
   assign rd_take = access && !pwrite;

   always_comb
   begin
      apb_d = apb_q;
      case (apb_q)
         sense_pkg::APB_IDLE:
            if (psel && !penable)
               apb_d = sense_pkg::APB_WAIT;
         sense_pkg::APB_WAIT:
            if (psel && penable)
               apb_d = sense_pkg::APB_DONE;
         sense_pkg::APB_DONE:
            apb_d = sense_pkg::APB_IDLE;
         default:
            apb_d = sense_pkg::APB_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         apb_q <= sense_pkg::APB_IDLE;
      else
         apb_q <= apb_d;
   end

   // answer flops: pready, read data and error for unmapped words
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= access;
         pslverr <= access && !mapped(paddr);
         if (rd_take)
            prdata <= mapped(paddr) ? rd_word : '0;
      end
   end

   // configuration register, byte strobes honoured
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_q <= `CONFIG_RESET;
      else if (wr_take && (idx == `IDX_CONFIG))
      begin
         if (pstrb[0])
            cfg_q[7:0] <= pwdata[7:0];
         if (pstrb[1])
            cfg_q[15:8] <= pwdata[15:8];
         if (pstrb[2])
            cfg_q[23:16] <= pwdata[23:16];
         if (pstrb[3])
            cfg_q[31:24] <= pwdata[31:24];
      end
   end

   // write-one-to-clear strobes
   assign clr_sense = wr_take && (idx == `IDX_CLEAR) && pstrb[0] &&
                      pwdata[`CLR_SENSE];
   assign clr_uc    = (wr_take && (idx == `IDX_CLEAR) && pstrb[0] &&
                       pwdata[`CLR_UNIT_CHECK]) || chan.status_taken;

   // sticky sense condition detection
   always_comb
   begin
      flag_set = '0;
      flag_set[`F_TAPE_IND]   = ext && drv.eot_marker && drv.forward;
      flag_set[`F_WPARITY]    = drv.write_parity_bad;
      flag_set[`F_START_READ] = drv.read_op && drv.inter_block_gap &&
                                drv.beginning_burst &&
                                !drv.ones_marker;
      flag_set[`F_VELOCITY]   = drv.velocity_error;
      flag_set[`F_WTM_MISS]   = drv.write_tape_mark_op &&
                                drv.block_missing;
      flag_set[`F_DRV_REJECT] = (drv.motion_cmd && !drv.drive_ready) ||
                                drv.read_status_change;
   end

   genvar g;
   generate
      for (g = 0; g < `NFLAGS; g = g + 1)
      begin : flags
         sense_flag u_flag (
            .pclk    (pclk),
            .presetn (presetn),
            .set     (flag_set[g]),
            .clr     (clr_sense),
            .q       (flag_q[g])
         );
      end
      // primed maps are bit reversed inside each byte
      for (g = 0; g < 8; g = g + 1)
      begin : primed_map
         assign primed_low[g]  = primed_q[7 - g];
         assign primed_high[g] = primed_q[15 - g];
      end
   endgenerate

   // live levels sampled for the sense bytes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lwr_q     <= 1'b0;
         reserve_q <= 1'b0;
         primed_q  <= '0;
      end
      else
      begin
         lwr_q     <= drv.loop_write_read;
         reserve_q <= drv.reserved;
         primed_q  <= drv.primed;
      end
   end

   // unit check causes
   assign uc_event = (chan.test_io && !drv.drive_ready) ||
                     (chan.start_io && !chan.cmd_is_sense &&
                      !drv.drive_ready) ||
                     (drv.backward_op && !drv.rewind_op &&
                      drv.load_point) ||
                     drv.rewind_unload ||
                     drv.not_capable;

   // channel status, held until accepted; a new cause beats the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         uc_q  <= 1'b0;
         de_q  <= 1'b0;
         cue_q <= 1'b0;
      end
      else
      begin
         if (uc_event)
            uc_q <= 1'b1;
         else if (clr_uc)
            uc_q <= 1'b0;
         if (drv.rewind_unload)
         begin
            de_q  <= 1'b1;
            cue_q <= 1'b1;
         end
         else if (clr_uc)
         begin
            de_q  <= 1'b0;
            cue_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unit_check <= 1'b0;
         device_end <= 1'b0;
         cu_end     <= 1'b0;
      end
      else
      begin
         unit_check <= uc_q;
         device_end <= de_q;
         cu_end     <= cue_q;
      end
   end

   // select propagation and block indication
   select_block u_select (
      .pclk         (pclk),
      .presetn      (presetn),
      .select_in    (chan.select_in),
      .address_out  (chan.address_out),
      .bus_out      (chan.bus_out),
      .unit_base    (cfg_q.unit_base),
      .blocked_q    (select_blocked),
      .select_out_q (select_out)
   );

   // sense byte assembly; all other bits stay zero
   always_comb
   begin
      rd_word = '0;
      case (idx)
         `IDX_DRIVE_COND:
         begin
            rd_word[`B4_REJECT]     = flag_q[`F_DRV_REJECT];
            rd_word[`B4_TAPE_IND]   = flag_q[`F_TAPE_IND];
            rd_word[`B4_WPARITY]    = flag_q[`F_WPARITY];
            rd_word[`B4_START_READ] = !ext &&
                                      flag_q[`F_START_READ];
            rd_word[`B4_LWR]        = ext && lwr_q;
         end
         `IDX_SUBSYS_MODE:
         begin
            rd_word[`B5_NEW_SUBSYS] = ext;
            rd_word[`B5_START_READ] = ext &&
                                      flag_q[`F_START_READ];
         end
         `IDX_VEL_RESERVE:
         begin
            if (ext)
            begin
               rd_word[`B9_VELOCITY] = flag_q[`F_VELOCITY];
               rd_word[`B9_RESERVE]  = reserve_q &&
                                       cfg_q.two_channel_switch;
            end
         end
         `IDX_TM_CHECK:
            rd_word[`B10_WTM_MISS] = ext && flag_q[`F_WTM_MISS];
         `IDX_FEAT_ID_HI:
            if (ext)
               rd_word[7:0] = {cfg_q.serial_id[13:8],
                               cfg_q.features};
         `IDX_ID_LOW:
            if (ext)
               rd_word[7:0] = cfg_q.serial_id[7:0];
         `IDX_SW_FEATURES:
            if (ext)
               rd_word[7:0] = {cfg_q.revision_level,
                               cfg_q.switch_code,
                               cfg_q.two_channel_switch};
         `IDX_PRIMED_LOW:
            if (ext)
               rd_word[7:0] = primed_low;
         `IDX_PRIMED_HIGH:
            if (ext)
               rd_word[7:0] = primed_high;
         `IDX_CONFIG:
            rd_word = cfg_q;
         `IDX_STATUS:
            rd_word[3:0] = {select_blocked, cue_q, de_q, uc_q};
         default:
            rd_word = '0;
      endcase
   end

endmodule : tape_control_sense_status

/* sim/sense_status_chk.sv */
`timescale 1ns/1ns
`include "sense_params.svh"
module sense_status_chk (
   input wire logic                     pclk,
   input wire logic                     presetn,
   input wire logic                     psel,
   input wire logic                     penable,
   input wire logic                     pready,
   input wire logic                     pslverr,
   input wire sense_pkg::drive_events_s drv,
   input wire sense_pkg::channel_req_s  chan,
   input wire logic                     unit_check,
   input wire logic                     device_end,
   input wire logic                     cu_end,
   input wire logic                     select_out,
   input wire logic                     select_blocked
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // access phase still waiting for its answer
   sequence s_wait;
      psel && penable && !pready;
   endsequence
   // unit check shows within the two-flop path
   sequence s_uc;
      ##[1:2] unit_check;
   endsequence
   chk_apb_one_wait: assert property (psel && !penable |=> s_wait ##1 pready)
      else $error("apb answer not after one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_uc_test_io: assert property (
      chan.test_io && !drv.drive_ready |-> s_uc)
      else $error("no unit check on test io");
   chk_uc_start_io: assert property (
      chan.start_io && !chan.cmd_is_sense && !drv.drive_ready |-> s_uc)
      else $error("no unit check on start io");
   chk_uc_load_pt: assert property (
      drv.backward_op && !drv.rewind_op && drv.load_point |-> s_uc)
      else $error("no unit check at load point");
   chk_uc_unload: assert property (
      drv.rewind_unload |-> ##[1:2] (unit_check && device_end && cu_end))
      else $error("unload status incomplete");
   chk_uc_not_capable: assert property (drv.not_capable |-> s_uc)
      else $error("no unit check on not capable");
   chk_sel_blocked: assert property (select_blocked |-> !select_out)
      else $error("select passed while blocked");
   chk_sel_drop: assert property (
      !chan.select_in |=> !select_out && !select_blocked)
      else $error("select state kept after select drop");
endmodule : sense_status_chk
bind tape_control_sense_status sense_status_chk u_chk (.pclk, .presetn,
   .psel, .penable, .pready, .pslverr, .drv, .chan, .unit_check,
   .device_end, .cu_end, .select_out, .select_blocked);

/* sim/channel_model.sv */
`timescale 1ns/1ns
// host channel side: requests, status taking, select and bus-out
module channel_model (
   input  wire logic               pclk,
   output sense_pkg::channel_req_s chan
);
   initial chan = '0;
   // hold a request for n edges; bus-out is not held afterwards,
   // so it shows the inverse of the last value
   task automatic drive_req(input sense_pkg::channel_req_s v, input int n);
      @(posedge pclk);
      chan <= v;
      repeat (n) @(posedge pclk);
      chan <= '{bus_out: ~v.bus_out, default: '0};
   endtask : drive_req
endmodule : channel_model

/* sim/tb_top.sv */
`timescale 1ns/1ns
`include "sense_params.svh"
module tb_top;
   logic                     pclk;
   logic                     presetn;
   logic                     psel;
   logic                     penable;
   logic                     pwrite;
   logic [7:0]               paddr;
   logic [31:0]              pwdata;
   logic [3:0]               pstrb;
   logic                     pready;
   logic [31:0]              prdata;
   logic                     pslverr;
   sense_pkg::drive_events_s drv;
   sense_pkg::drive_events_s idle;
   sense_pkg::channel_req_s  chan;
   sense_pkg::config_s       cfg;
   logic                     unit_check;
   logic                     device_end;
   logic                     cu_end;
   logic                     select_out;
   logic                     select_blocked;
   int                       err_count;
   int                       checks;

   tape_control_sense_status u_tape_control_sense_status (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
      .pslverr, .drv, .chan, .unit_check, .device_end, .cu_end,
      .select_out, .select_blocked);
   channel_model u_channel_model (.pclk, .chan);

   // 10 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         err_count++;
         tally_and_finish();
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [5:0] i, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, {i, 2'b00}, 32'h0, r, e);
      chk($sformatf("reg %h", i), r, exp);
      chk("slverr", {31'h0, e}, 32'h0);
   endtask : rd

   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, {i, 2'b00}, d, r, e);
   endtask : wr

   // one-cycle drive event over the idle levels
   task automatic pd(input sense_pkg::drive_events_s v);
      @(posedge pclk);
      drv <= v;
      @(posedge pclk);
      drv <= idle;
   endtask : pd

   // burst then gap on a read, before the ones marker
   task automatic start_read;
      sense_pkg::drive_events_s v;
      v = idle;
      v.read_op = 1'b1;
      v.beginning_burst = 1'b1;
      pd(v);
      v.inter_block_gap = 1'b1;
      pd(v);
   endtask : start_read

   task automatic see_status(input logic [2:0] exp);
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk("uc de cue", {29'h0, unit_check, device_end, cu_end}, {29'h0, exp});
   endtask : see_status

   task automatic take_status;
      sense_pkg::channel_req_s c;
      c = '0;
      c.status_taken = 1'b1;
      u_channel_model.drive_req(c, 1);
      see_status(3'b000);
   endtask : take_status

   task automatic t_defaults;
      logic [31:0] r;
      logic        e;
      rd(`IDX_CONFIG, 32'h1);
      rd(`IDX_SUBSYS_MODE, 32'h2);
      rd(`IDX_SW_FEATURES, 32'h0);
      wr(`IDX_DRIVE_COND, 32'hFF);
      rd(`IDX_DRIVE_COND, 32'h0);
      apb(1'b0, 8'h01, 32'h0, r, e);
      chk("unaligned err", {31'h0, e}, 32'h1);
      chk("unaligned data", r, 32'h0);
      $display("test defaults done");
   endtask : t_defaults

   task automatic t_flags;
      sense_pkg::drive_events_s v;
      v = idle;
      v.eot_marker = 1'b1;
      v.forward = 1'b1;
      v.write_parity_bad = 1'b1;
      v.velocity_error = 1'b1;
      v.write_tape_mark_op = 1'b1;
      v.block_missing = 1'b1;
      pd(v);
      v = idle;
      v.motion_cmd = 1'b1;
      v.drive_ready = 1'b0;
      pd(v);
      idle.loop_write_read = 1'b1;
      start_read();
      rd(`IDX_DRIVE_COND, 32'h2E);
      idle.loop_write_read = 1'b0;
      drv <= idle;
      rd(`IDX_SUBSYS_MODE, 32'h12);
      rd(`IDX_VEL_RESERVE, 32'h02);
      rd(`IDX_TM_CHECK, 32'h10);
      rd(`IDX_SPARE_SIX, 32'h0);
      rd(`IDX_ERASE_STAT, 32'h0);
      wr(`IDX_CLEAR, 32'h1);
      rd(`IDX_DRIVE_COND, 32'h0);
      rd(`IDX_VEL_RESERVE, 32'h0);
      $display("test flags done");
   endtask : t_flags

   task automatic t_ids;
      cfg = '0;
      cfg.extended_mode = 1'b1;
      cfg.two_channel_switch = 1'b1;
      cfg.switch_code = 3'b100;
      cfg.revision_level = 4'h9;
      cfg.serial_id = 14'h2A5B;
      cfg.features = 2'b10;
      cfg.unit_base = 4'h3;
      wr(`IDX_CONFIG, cfg);
      rd(`IDX_FEAT_ID_HI, 32'hAA);
      rd(`IDX_ID_LOW, 32'h5B);
      rd(`IDX_SW_FEATURES, 32'h99);
      idle.reserved = 1'b1;
      idle.primed = 16'h0609;
      drv <= idle;
      rd(`IDX_VEL_RESERVE, 32'h80);
      rd(`IDX_PRIMED_LOW, 32'h90);
      rd(`IDX_PRIMED_HIGH, 32'h60);
      cfg.two_channel_switch = 1'b0;
      cfg.switch_code = 3'b000;
      wr(`IDX_CONFIG, cfg);
      rd(`IDX_VEL_RESERVE, 32'h0);
      rd(`IDX_SW_FEATURES, 32'h90);
      pstrb <= 4'h2;
      wr(`IDX_CONFIG, 32'h0);
      pstrb <= 4'hF;
      rd(`IDX_SW_FEATURES, 32'h10);
      idle.reserved = 1'b0;
      drv <= idle;
      $display("test ids done");
   endtask : t_ids

   task automatic t_legacy;
      sense_pkg::drive_events_s v;
      cfg.extended_mode = 1'b0;
      wr(`IDX_CONFIG, cfg);
      start_read();
      v = idle;
      v.eot_marker = 1'b1;
      v.forward = 1'b1;
      v.velocity_error = 1'b1;
      idle.loop_write_read = 1'b1;
      pd(v);
      rd(`IDX_DRIVE_COND, 32'h10);
      rd(`IDX_SUBSYS_MODE, 32'h0);
      rd(`IDX_VEL_RESERVE, 32'h0);
      rd(`IDX_FEAT_ID_HI, 32'h0);
      idle.loop_write_read = 1'b0;
      drv <= idle;
      cfg.extended_mode = 1'b1;
      wr(`IDX_CONFIG, cfg);
      wr(`IDX_CLEAR, 32'h1);
      $display("test legacy done");
   endtask : t_legacy

   task automatic t_unit_check;
      sense_pkg::channel_req_s  c;
      sense_pkg::drive_events_s v;
      idle.drive_ready = 1'b0;
      drv <= idle;
      c = '0;
      c.test_io = 1'b1;
      u_channel_model.drive_req(c, 1);
      see_status(3'b100);
      take_status();
      c = '0;
      c.start_io = 1'b1;
      c.cmd_is_sense = 1'b1;
      u_channel_model.drive_req(c, 1);
      see_status(3'b000);
      c.cmd_is_sense = 1'b0;
      u_channel_model.drive_req(c, 1);
      see_status(3'b100);
      take_status();
      idle.drive_ready = 1'b1;
      drv <= idle;
      v = idle;
      v.backward_op = 1'b1;
      v.load_point = 1'b1;
      v.rewind_op = 1'b1;
      pd(v);
      see_status(3'b000);
      v.rewind_op = 1'b0;
      pd(v);
      see_status(3'b100);
      take_status();
      v = idle;
      v.not_capable = 1'b1;
      pd(v);
      see_status(3'b100);
      wr(`IDX_CLEAR, 32'h2);
      see_status(3'b000);
      v = idle;
      v.rewind_unload = 1'b1;
      pd(v);
      see_status(3'b111);
      rd(`IDX_STATUS, 32'h7);
      take_status();
      $display("test unit check done");
   endtask : t_unit_check

   task automatic t_select;
      sense_pkg::channel_req_s c;
      c = '0;
      c.select_in = 1'b1;
      c.address_out = 1'b1;
      c.bus_out = 8'h35;
      fork
         u_channel_model.drive_req(c, 4);
         begin
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            chk("own blocked", {31'h0, select_blocked}, 32'h1);
            chk("own passed", {31'h0, select_out}, 32'h0);
         end
      join
      c.bus_out = 8'h55;
      fork
         u_channel_model.drive_req(c, 4);
         begin
            repeat (3) @(posedge pclk);
            @(negedge pclk);
            chk("other blocked", {31'h0, select_blocked}, 32'h0);
            chk("other passed", {31'h0, select_out}, 32'h1);
         end
      join
      $display("test select done");
   endtask : t_select

   // reset, then the scenarios in turn
   initial
   begin
      err_count = 0;
      checks = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      cfg = '0;
      idle = '0;
      idle.drive_ready = 1'b1;
      drv = idle;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_defaults();
      t_flags();
      t_ids();
      t_legacy();
      t_unit_check();
      t_select();
      tally_and_finish();
   end
endmodule : tb_top
